// *** design/sci_rx_status_and_baud_gen.sv ***
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sci_defs.svh"

module sci_rx_status_and_baud_gen
	import sci_pkg::*;
#(
	parameter int IDLE_BITS = `IDLE_BITS_DEF
)
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial pins
	input  wire logic        rxd,
	input  wire logic        oscillator_clock,
	// Transmitter side
	output logic      [7:0]  tx_data,
	output logic             tx_load,
	output logic             tx_bit_tick,
	// Status out
	output logic             rx_full_flag,
	output logic             err_irq
);

	localparam logic [7:0] IDLE_TICKS = 8'(IDLE_BITS * `SLOTS_PER_BIT);

	generate
		if (IDLE_BITS < 1 || IDLE_BITS > 15)
		begin : g_bad_idle
			$error("IDLE_BITS must lie in 1..15");
		end
	endgenerate

	sci_state_t q;
	sci_state_t d;
	baud_cfg_t  bcfg;
	logic       rx_tick;
	logic       acc;
	logic       rd;
	logic [7:0] off;
	logic       rxl;
	logic       nine;
	logic [7:0] ch_byte;
	logic       ch_ninth;
	logic       ch_par;
	logic       ch_zero;
	logic [3:0] ch_bits;

	function automatic logic [7:0] reg_byte(input sci_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`OFS_STATUS_ONE:
			begin
				v[`S1_FULL_BIT] = s.rx_full_flag;
				v[`S1_FE_BIT] = s.framing_error_flag;
				v[`S1_PE_BIT] = s.parity_error_flag;
			end
			`OFS_STATUS_TWO:
			begin
				v[`S2_BREAK_BIT] = s.break_detect_flag;
				v[`S2_ACTIVE_BIT] = s.rx_active_flag;
			end
			`OFS_CONTROL_3:
			begin
				v[`C3_NINTH_BIT] = s.ninth_rx_bit;
				v[`C3_FRAMING_ERROR_IRQ_EN_BIT] = s.framing_error_irq_en;
				v[`C3_PARITY_ERROR_IRQ_EN_BIT] = s.parity_error_irq_en;
			end
			`OFS_BAUD_SELECT: v = s.baud_select;
			`OFS_RX_CONFIG:   v = {4'h0, s.rx_config};
			`OFS_DATA_BUFFER: v = s.rx_byte;
			default:          v = 8'h00;
		endcase
		return v;
	endfunction

	assign bcfg.src_osc = q.rx_config[`CF_SRC_BIT];
	assign bcfg.prescale_sel = q.baud_select[`BR_PRE_LSB +: 2];
	assign bcfg.divisor_sel = q.baud_select[`BR_DIV_LSB +: 3];

	baud_rate_gen u_baud (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.oscillator_clock (oscillator_clock),
		.cfg              (bcfg),
		.rx_tick          (rx_tick),
		.bit_tick         (tx_bit_tick)
	);

	always_comb
	begin
		d = q;
		d.tx_load = 1'b0;
		d.rx_s1 = rxd;
		d.rx_s2 = q.rx_s1;
		rxl = q.rx_s2;
		nine = q.rx_config[`CF_NINE_BIT];
		acc = hsel & htrans[1] & hready;
		rd = acc & ~hwrite;
		off = haddr[7:0];

		// Write data phase
		if (q.wr_pend)
		begin
			case (q.wr_addr)
				`OFS_CONTROL_3:
				begin
					d.framing_error_irq_en = hwdata[`C3_FRAMING_ERROR_IRQ_EN_BIT];
					d.parity_error_irq_en = hwdata[`C3_PARITY_ERROR_IRQ_EN_BIT];
				end
				`OFS_BAUD_SELECT:
					d.baud_select = hwdata[7:0] & 8'h37;
				`OFS_RX_CONFIG:
					d.rx_config = hwdata[3:0];
				`OFS_DATA_BUFFER:
				begin
					d.tx_data = hwdata[7:0];
					d.tx_load = 1'b1;
				end
				default:
					d.tx_load = 1'b0;
			endcase
		end
		d.wr_pend = acc & hwrite;
		d.wr_addr = off;

		// Read data registered for the data phase
		d.hrdata = rd ? {24'h000000, reg_byte(q, off)} : 32'h00000000;

		if (rd && off == `OFS_STATUS_ONE)
		begin
			d.arm_full = q.rx_full_flag;
			d.arm_fe = q.framing_error_flag;
			d.arm_pe = q.parity_error_flag;
		end
		if (rd && off == `OFS_STATUS_TWO)
			d.arm_bk = q.break_detect_flag;
		if (rd && off == `OFS_DATA_BUFFER)
		begin
			if (q.arm_full)
				d.rx_full_flag = 1'b0;
			if (q.arm_fe)
				d.framing_error_flag = 1'b0;
			if (q.arm_pe)
				d.parity_error_flag = 1'b0;
			if (q.arm_bk)
				d.break_detect_flag = 1'b0;
			d.arm_full = 1'b0;
			d.arm_fe = 1'b0;
			d.arm_pe = 1'b0;
			d.arm_bk = 1'b0;
		end

		// Character assembly; flag sets below override the clears above
		ch_bits = nine ? 4'h9 : 4'h8;
		ch_byte = nine ? q.shift[7:0] : q.shift[8:1];
		ch_ninth = q.shift[8];
		ch_par = nine ? ^q.shift : ^q.shift[8:1];
		ch_zero = nine ? (q.shift == 9'h000) : (q.shift[8:1] == 8'h00);

		case (q.st)
			RX_SEARCH:
			begin
				if (rx_tick)
				begin
					if (!rxl)
					begin
						d.rx_active_flag = 1'b1;
						d.st = RX_START;
						d.phase = 4'h0;
						d.idle_cnt = 8'h00;
					end
					else
					begin
						d.brk_armed = 1'b1;
						if (q.idle_cnt < IDLE_TICKS)
							d.idle_cnt = q.idle_cnt + 8'h01;
						if (q.idle_cnt == IDLE_TICKS - 8'h01)
							d.rx_active_flag = 1'b0;
					end
				end
			end
			RX_START:
			begin
				if (rx_tick)
				begin
					d.phase = q.phase + 4'h1;
					if (q.phase == `START_CHECK_SLOT)
					begin
						if (rxl)
						begin
							d.rx_active_flag = 1'b0;
							d.st = RX_SEARCH;
						end
						else
						begin
							d.st = RX_DATA;
							d.phase = 4'h0;
							d.nbits = 4'h0;
						end
					end
				end
			end
			RX_DATA:
			begin
				if (rx_tick)
				begin
					d.phase = q.phase + 4'h1;
					if (q.phase == `BIT_SAMPLE_SLOT)
					begin
						d.shift = {rxl, q.shift[8:1]};
						d.nbits = q.nbits + 4'h1;
						if (q.nbits == ch_bits - 4'h1)
							d.st = RX_STOP;
					end
				end
			end
			RX_STOP:
			begin
				if (rx_tick)
				begin
					d.phase = q.phase + 4'h1;
					if (q.phase == `BIT_SAMPLE_SLOT)
					begin
						d.st = RX_SEARCH;
						d.idle_cnt = 8'h00;
						d.rx_byte = ch_byte;
						d.ninth_rx_bit = ch_ninth;
						d.rx_full_flag = 1'b1;
						if (!rxl)
							d.framing_error_flag = 1'b1;
						if (q.rx_config[`CF_PAR_EN_BIT] && (ch_par != q.rx_config[`CF_PAR_ODD_BIT]))
							d.parity_error_flag = 1'b1;
						if (ch_zero && !rxl)
						begin
							if (nine)
								d.ninth_rx_bit = 1'b0;
							if (q.brk_armed)
								d.break_detect_flag = 1'b1;
							d.brk_armed = 1'b0;
						end
					end
				end
			end
			default:
				d.st = RX_SEARCH;
		endcase

		d.err_irq = (d.framing_error_flag & d.framing_error_irq_en) |
			(d.parity_error_flag & d.parity_error_irq_en);
	end

	// Data buffer contents and ninth bit keep their value through reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q.rx_s1 <= 1'b1;
			q.rx_s2 <= 1'b1;
			q.st <= RX_SEARCH;
			q.phase <= 4'h0;
			q.nbits <= 4'h0;
			q.shift <= 9'h000;
			q.idle_cnt <= 8'h00;
			q.brk_armed <= 1'b1;
			q.rx_full_flag <= 1'b0;
			q.framing_error_flag <= 1'b0;
			q.parity_error_flag <= 1'b0;
			q.break_detect_flag <= 1'b0;
			q.rx_active_flag <= 1'b0;
			q.arm_full <= 1'b0;
			q.arm_fe <= 1'b0;
			q.arm_pe <= 1'b0;
			q.arm_bk <= 1'b0;
			q.framing_error_irq_en <= 1'b0;
			q.parity_error_irq_en <= 1'b0;
			q.baud_select <= `BAUD_RESET;
			q.rx_config <= `CONFIG_RESET;
			q.tx_load <= 1'b0;
			q.err_irq <= 1'b0;
			q.wr_pend <= 1'b0;
			q.wr_addr <= 8'h00;
			q.hrdata <= 32'h00000000;
			q.hreadyout <= 1'b1;
		end
		else
			q <= d;
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hreadyout;
	assign hresp = 1'b0;
	assign tx_data = q.tx_data;
	assign tx_load = q.tx_load;
	assign rx_full_flag = q.rx_full_flag;
	assign err_irq = q.err_irq;

endmodule

// *** include/sci_defs.svh ***
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// Register byte offsets on the bus
`define OFS_STATUS_ONE   8'h00
`define OFS_STATUS_TWO   8'h04
`define OFS_CONTROL_3    8'h08
`define OFS_BAUD_SELECT  8'h0C
`define OFS_RX_CONFIG    8'h10
`define OFS_DATA_BUFFER  8'h18

// Field positions
`define S1_FULL_BIT      5
`define S1_FE_BIT        1
`define S1_PE_BIT        0
`define S2_BREAK_BIT     1
`define S2_ACTIVE_BIT    0
`define C3_NINTH_BIT     7
`define C3_FRAMING_ERROR_IRQ_EN_BIT      1
`define C3_PARITY_ERROR_IRQ_EN_BIT      0
`define BR_PRE_LSB       4
`define BR_DIV_LSB       0
`define CF_SRC_BIT       0
`define CF_NINE_BIT      1
`define CF_PAR_EN_BIT    2
`define CF_PAR_ODD_BIT   3

// Reset values
`define BAUD_RESET       8'h00
`define CONFIG_RESET     4'h0

// Prescale divisors by code
`define PRESCALE_DIV_0   4'h1
`define PRESCALE_DIV_1   4'h3
`define PRESCALE_DIV_2   4'h4
`define PRESCALE_DIV_3   4'hD

// Timing counts
`define SLOTS_PER_BIT    16
`define DIV64_PER_SLOT   4
`define START_CHECK_SLOT 4'h7
`define BIT_SAMPLE_SLOT  4'hF
`define IDLE_BITS_DEF    10

`endif

// *** include/sci_pkg.sv ***
package sci_pkg;

	typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} rx_state_t;

	typedef struct packed {
		logic       src_osc;
		logic [1:0] prescale_sel;
		logic [2:0] divisor_sel;
	} baud_cfg_t;

	typedef struct packed {
		logic       osc_s1;
		logic       osc_s2;
		logic       osc_prev;
		logic [3:0] pre_cnt;
		logic [8:0] div_cnt;
		logic [3:0] slot;
		logic       rx_tick;
		logic       bit_tick;
	} baud_state_t;

	typedef struct packed {
		logic       rx_s1;
		logic       rx_s2;
		rx_state_t  st;
		logic [3:0] phase;
		logic [3:0] nbits;
		logic [8:0] shift;
		logic [7:0] idle_cnt;
		logic       brk_armed;
		logic [7:0] rx_byte;
		logic       ninth_rx_bit;
		logic       rx_full_flag;
		logic       framing_error_flag;
		logic       parity_error_flag;
		logic       break_detect_flag;
		logic       rx_active_flag;
		logic       arm_full;
		logic       arm_fe;
		logic       arm_pe;
		logic       arm_bk;
		logic       framing_error_irq_en;
		logic       parity_error_irq_en;
		logic [7:0] baud_select;
		logic [3:0] rx_config;
		logic [7:0] tx_data;
		logic       tx_load;
		logic       err_irq;
		logic       wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
		logic       hreadyout;
	} sci_state_t;

endpackage

// *** design/baud_rate_gen.sv ***
`timescale 1ns/1ps
`include "sci_defs.svh"

module baud_rate_gen
	import sci_pkg::*;
(
	// Clock and reset
	input  wire logic      hclk,
	input  wire logic      hresetn,
	// Oscillator pin and setting
	input  wire logic      oscillator_clock,
	input  wire baud_cfg_t cfg,
	// Ticks
	output logic           rx_tick,
	output logic           bit_tick
);

	baud_state_t q;
	baud_state_t d;
	logic        src_tick;
	logic        pre_tick;
	logic [3:0]  pd;
	logic [8:0]  lim;

	function automatic logic [3:0] prescale_div(input logic [1:0] code);
		case (code)
			2'h0:    prescale_div = `PRESCALE_DIV_0;
			2'h1:    prescale_div = `PRESCALE_DIV_1;
			2'h2:    prescale_div = `PRESCALE_DIV_2;
			default: prescale_div = `PRESCALE_DIV_3;
		endcase
	endfunction

	always_comb
	begin
		d = q;
		d.osc_s1 = oscillator_clock;
		d.osc_s2 = q.osc_s1;
		d.osc_prev = q.osc_s2;
		d.rx_tick = 1'b0;
		d.bit_tick = 1'b0;
		pre_tick = 1'b0;
		// source select
		// Oscillator is sampled, so it must run below half the bus clock
		src_tick = cfg.src_osc ? (q.osc_s2 & ~q.osc_prev) : 1'b1;
		pd = prescale_div(cfg.prescale_sel);
		lim = 9'((10'(`DIV64_PER_SLOT) << cfg.divisor_sel) - 10'h001);
		if (src_tick)
		begin
			if (q.pre_cnt >= pd - 4'h1)
			begin
				d.pre_cnt = 4'h0;
				pre_tick = 1'b1;
			end
			else
				d.pre_cnt = q.pre_cnt + 4'h1;
		end
		// sixteen slots per bit
		// Compare with >= so a smaller setting written mid-count takes effect at once
		if (pre_tick)
		begin
			if (q.div_cnt >= lim)
			begin
				d.div_cnt = 9'h000;
				d.rx_tick = 1'b1;
				d.slot = q.slot + 4'h1;
				d.bit_tick = (q.slot == 4'hF);
			end
			else
				d.div_cnt = q.div_cnt + 9'h001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	assign rx_tick = q.rx_tick;
	assign bit_tick = q.bit_tick;

endmodule

// *** verif/serial_far_end.sv ***
`timescale 1ns/1ps
module serial_far_end
(
	// Clock
	input  wire logic hclk,
	// Serial line
	output logic      rxd
);
	// One bit at the quickest baud setting, in bus clocks
	localparam int BIT_CYCLES = 64;

	// Line idles high between frames, as a pulled-up receive pin would
	initial rxd = 1'b1;

	task automatic send(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd <= bits[i];
			repeat (BIT_CYCLES) @(posedge hclk);
		end
		rxd <= 1'b1;
	endtask

	// Low pulse shorter than half a bit, seen as a false start
	task automatic glitch(input int c);
		rxd <= 1'b0;
		repeat (c) @(posedge hclk);
		rxd <= 1'b1;
	endtask
endmodule

// *** verif/sci_rx_assertions.sv ***
`timescale 1ns/1ps
module sci_rx_checker
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Block outputs
	input wire logic [7:0]  tx_data,
	input wire logic        tx_load,
	input wire logic        tx_bit_tick,
	input wire logic        rx_full_flag,
	input wire logic        err_irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic rd     = hsel && htrans[1] && hready && !hwrite;
	wire logic wr     = hsel && htrans[1] && hready && hwrite;
	wire logic rd_buf = rd && haddr[7:0] == 8'h18;
	wire logic wr_buf = wr && haddr[7:0] == 8'h18;
	wire logic wr_ctl = wr && haddr[7:0] == 8'h08;

	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	load_pulse_a: assert property (wr_buf |-> ##2 tx_load && tx_data == $past(hwdata[7:0]))
		else $error("data write did not load transmit byte");
	load_cause_a: assert property (tx_load |-> $past(wr_buf, 2))
		else $error("transmit load without data write");
	tick_gap_a: assert property (tx_bit_tick |=> !tx_bit_tick [*8])
		else $error("bit ticks too close");
	rdata_idle_a: assert property (!rd |=> hrdata == 32'h0)
		else $error("read data without a read");
	full_read_a: assert property (rd && haddr[7:0] == 8'h00 |=> hrdata[5] == $past(rx_full_flag))
		else $error("status full bit differs from pin");
	// Full may only drop on the data read of a clearing sequence
	full_clear_a: assert property ($fell(rx_full_flag) |-> $past(rd_buf))
		else $error("full flag dropped without data read");
	irq_drop_a: assert property ($fell(err_irq) |->
		$past(rd_buf) || $past(rd_buf, 2) || $past(wr_ctl, 2) || $past(wr_ctl, 3))
		else $error("error request dropped without cause");

	cover property (tx_load);
	cover property ($fell(rx_full_flag));
	cover property ($rose(err_irq));
endmodule

bind sci_rx_status_and_baud_gen sci_rx_checker chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .tx_data, .tx_load, .tx_bit_tick, .rx_full_flag, .err_irq);

// *** verif/sci_rx_status_and_baud_gen_bench.sv ***
`timescale 1ns/1ps
module sci_rx_status_and_baud_gen_bench;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b0;
	logic [31:0]      haddr = 32'h0;
	logic [1:0]       htrans = 2'h0;
	logic             hwrite = 1'b0;
	logic [31:0]      hwdata = 32'h0;
	logic             oscillator_clock = 1'b0;
	logic [31:0]      r;
	int               n_errors = 0;
	int               checks_done = 0;
	wire logic [31:0] hrdata;
	wire logic [7:0]  tx_data;
	wire logic        hready, hresp, rxd, tx_load, tx_bit_tick, rx_full_flag, err_irq;

	sci_rx_status_and_baud_gen uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .rxd, .oscillator_clock, .tx_data, .tx_load, .tx_bit_tick,
		.rx_full_flag, .err_irq);
	serial_far_end far (.hclk, .rxd);

	always #4 hclk = ~hclk;
	// Offset keeps oscillator edges away from bus clock edges
	initial
	begin
		#1;
		forever #20 oscillator_clock = ~oscillator_clock;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, r, e);
	endtask

	task automatic gap(output int n);
		n = 0;
		@(posedge hclk iff tx_bit_tick === 1'b1);
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (tx_bit_tick !== 1'b1);
	endtask

	task automatic frame(input logic [7:0] d, input logic stp);
		far.send({22'h0, stp, d, 1'b0}, 10);
		repeat (8) @(posedge hclk);
	endtask

	task automatic test_regs();
		rd(8'h0C, 32'h0, "baud reset");
		rd(8'h00, 32'h0, "status one reset");
		rd(8'h04, 32'h0, "status two reset");
		bus(1'b1, 8'h0C, 32'hFF);
		rd(8'h0C, 32'h37, "baud fields");
		bus(1'b1, 8'h00, 32'hFF);
		rd(8'h00, 32'h0, "status one read only");
		rd(8'h14, 32'h0, "unmapped");
	endtask

	task automatic test_rates();
		logic [7:0] cfg[8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h03, 8'h07, 8'h00};
		int per[8] = '{64, 192, 256, 832, 128, 512, 8192, 320};
		int n;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, 8'h10, {31'h0, i == 7});
			bus(1'b1, 8'h0C, {24'h0, cfg[i]});
			gap(n);
			gap(n);
			chk("bit period", n, per[i]);
		end
		bus(1'b1, 8'h10, 32'h0);
	endtask

	task automatic test_rx();
		frame(8'hA5, 1'b1);
		chk("full pin", rx_full_flag, 1'b1);
		rd(8'h00, 32'h20, "good byte status");
		// Write between status and data read: data read must still see the received byte
		bus(1'b1, 8'h18, 32'h5A);
		rd(8'h18, 32'hA5, "received byte");
		chk("transmit byte", tx_data, 8'h5A);
		chk("full after read", rx_full_flag, 1'b0);
		repeat (700) @(posedge hclk);
		rd(8'h04, 32'h0, "active after idle");
		far.glitch(12);
		// Start recheck falls well after this read, so the flag still stands
		rd(8'h04, 32'h1, "start seen");
		repeat (60) @(posedge hclk);
		rd(8'h04, 32'h0, "false start");
	endtask

	task automatic test_fe();
		bus(1'b1, 8'h08, 32'h02);
		frame(8'hBC, 1'b0);
		chk("fe request", err_irq, 1'b1);
		rd(8'h08, 32'h82, "ninth copy");
		rd(8'h18, 32'hBC, "fe data");
		rd(8'h00, 32'h22, "fe kept");
		rd(8'h18, 32'hBC, "fe clear");
		rd(8'h00, 32'h0, "fe cleared");
		chk("fe request off", err_irq, 1'b0);
	endtask

	task automatic test_pe();
		bus(1'b1, 8'h10, 32'h04);
		bus(1'b1, 8'h08, 32'h01);
		frame(8'h01, 1'b1);
		chk("pe request", err_irq, 1'b1);
		rd(8'h00, 32'h21, "pe set");
		bus(1'b0, 8'h18, 32'h0);
		rd(8'h00, 32'h0, "pe cleared");
		chk("pe request off", err_irq, 1'b0);
		frame(8'h81, 1'b1);
		rd(8'h00, 32'h20, "even parity");
		bus(1'b0, 8'h18, 32'h0);
		bus(1'b1, 8'h10, 32'h0C);
		frame(8'h01, 1'b1);
		rd(8'h00, 32'h20, "odd parity");
		bus(1'b0, 8'h18, 32'h0);
	endtask

	task automatic test_brk();
		bus(1'b1, 8'h10, 32'h02);
		bus(1'b1, 8'h08, 32'h00);
		// Two breaks with no high between them: only the first may flag
		fork
			far.send(32'h0, 24);
			begin
				repeat (760) @(posedge hclk);
				rd(8'h04, 32'h3, "break set");
				chk("break no request", err_irq, 1'b0);
				rd(8'h00, 32'h22, "break full fe");
				rd(8'h08, 32'h0, "break ninth");
				bus(1'b0, 8'h18, 32'h0);
				bus(1'b0, 8'h04, 32'h0);
				chk("break cleared", r[1], 1'b0);
			end
		join
		repeat (800) @(posedge hclk);
		bus(1'b0, 8'h04, 32'h0);
		chk("break not again", r[1], 1'b0);
		bus(1'b0, 8'h00, 32'h0);
		bus(1'b0, 8'h18, 32'h0);
		far.send(32'h0, 11);
		repeat (8) @(posedge hclk);
		// Reception flag may already have dropped on the false start after the break
		bus(1'b0, 8'h04, 32'h0);
		chk("break after high", r[1], 1'b1);
	endtask

	task automatic test_reset();
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b1, 8'h08, 32'h02);
		frame(8'hC3, 1'b0);
		chk("fe before reset", err_irq, 1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("request after reset", err_irq, 1'b0);
		rd(8'h00, 32'h0, "status one after reset");
		rd(8'h04, 32'h0, "status two after reset");
		rd(8'h08, 32'h80, "enables after reset");
		rd(8'h18, 32'hC3, "data kept over reset");
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge hclk);
		n_errors++;
		stop_test();
	end

	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_regs();
		test_rates();
		test_rx();
		test_fe();
		test_pe();
		test_brk();
		test_reset();
		stop_test();
	end
endmodule
